//--- timer8_mode_clock_compare_tb.sv
`include "tmc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module timer8_mode_clock_compare_tb;
    import tmc_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [9:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd_data;
    logic ext_pin, dir_a, dir_b, wa, wa_oe_n, wbo, wb_oe_n, fa, fb;
    logic pin_a, pin_b, pulse_req, e;
    logic [1:0] act;
    logic [2:0] md;
    int mismatches, check_count;
    int divs [6] = '{1, 1, 8, 64, 256, 1024};

    tmc_timer8 uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ext_count_pin_i(ext_pin),
        .port_dir_a_i(dir_a), .port_dir_b_i(dir_b), .wave_out_a_o(wa),
        .wave_out_a_oe_n_o(wa_oe_n), .wave_out_b_o(wbo),
        .wave_out_b_oe_n_o(wb_oe_n), .match_flag_a_o(fa),
        .match_flag_b_o(fb));

    tmc_pin_model pins (.clk_i(clk_i), .rst_i(rst_i),
        .pulse_req_i(pulse_req), .wave_a_i(wa), .oe_n_a_i(wa_oe_n),
        .wave_b_i(wbo), .oe_n_b_i(wb_oe_n), .ext_count_pin_o(ext_pin),
        .pin_a_o(pin_a), .pin_b_o(pin_b));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic we, input logic [7:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            chk({31'h0, wb_ack_o}, 32'h1);
            end_of_test();
        end
        rd_data = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd_data, {24'h0, exp});
    endtask : rd

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc_wait

    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, pulse_req} = 4'h0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        dir_a = 1'b1;
        dir_b = 1'b1;
        rst_i = 1'b1;
        mismatches = 0;
        check_count = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`TMC_IDX_CTRL_A, 8'h00);
        rd(`TMC_IDX_CTRL_B, 8'h00);
        rd(`TMC_IDX_COUNT, 8'h00);
        rd(`TMC_IDX_CMP_A, 8'h00);
        chk({30'h0, wa_oe_n, wb_oe_n}, 32'h3);
        rd(8'h30, 8'h00);
        note("reset");
        wr(`TMC_IDX_CTRL_A, 8'hFF);
        rd(`TMC_IDX_CTRL_A, 8'hF3);
        wr(`TMC_IDX_CTRL_A, 8'h00);
        wr(`TMC_IDX_CTRL_B, 8'h38);
        rd(`TMC_IDX_CTRL_B, 8'h08);
        wr(`TMC_IDX_CTRL_B, 8'h00);
        wr(`TMC_IDX_CMP_A, 8'hA5);
        rd(`TMC_IDX_CMP_A, 8'hA5);
        wr(`TMC_IDX_COUNT, 8'h3C);
        rd(`TMC_IDX_COUNT, 8'h3C);
        note("registers");
        // Actions set, clear, toggle applied by forced matches.
        e = 1'b0;
        for (int i = 0; i < 3; i++) begin
            act = (i == 0) ? 2'h3 : (i == 1) ? 2'h2 : 2'h1;
            e = (act == 2'h3) ? 1'b1 : (act == 2'h2) ? 1'b0 : ~e;
            wr(`TMC_IDX_CTRL_A, {act, act, 4'h0});
            wr(`TMC_IDX_CTRL_B, 8'hC0);
            cyc_wait(2);
            chk({30'h0, wa, wbo}, {30'h0, e, e});
            chk({30'h0, fa, fb}, 32'h0);
            rd(`TMC_IDX_CTRL_B, 8'h00);
        end
        chk({28'h0, wa_oe_n, wb_oe_n, pin_a, pin_b}, 32'h3);
        dir_a <= 1'b0;
        cyc_wait(3);
        chk({30'h0, wa_oe_n, pin_a}, 32'h2);
        dir_a <= 1'b1;
        wr(`TMC_IDX_CTRL_A, 8'h00);
        cyc_wait(2);
        chk({31'h0, wa_oe_n}, 32'h1);
        note("force");
        wr(`TMC_IDX_CTRL_A, 8'hC0);
        wr(`TMC_IDX_CTRL_B, 8'h80);
        e = 1'b1;
        for (int m = 0; m < 8; m++) begin
            md = 3'(m);
            wr(`TMC_IDX_CTRL_A, {6'h10, md[1:0]});
            wr(`TMC_IDX_CTRL_B, {4'h0, md[2], 3'h0});
            wr(`TMC_IDX_CTRL_B, {md[0] ? 4'h0 : 4'h8, md[2], 3'h0});
            e = md[0] ? e : ~e;
            cyc_wait(2);
            chk({31'h0, wa}, {31'h0, e});
        end
        wr(`TMC_IDX_CTRL_B, 8'h00);
        wr(`TMC_IDX_CTRL_A, 8'h00);
        note("modes");
        // Each window spans exactly four prescaled periods.
        for (int c = 0; c < 6; c++) begin
            wr(`TMC_IDX_COUNT, 8'h00);
            wr(`TMC_IDX_CTRL_B, 8'(c));
            cyc_wait(4 * divs[c] - 3);
            wr(`TMC_IDX_CTRL_B, 8'h00);
            rd(`TMC_IDX_COUNT, (c == 0) ? 8'h00 : 8'h04);
        end
        note("prescaler");
        wr(`TMC_IDX_CMP_A, 8'h05);
        wr(`TMC_IDX_CTRL_A, 8'h40);
        wr(`TMC_IDX_COUNT, 8'h05);
        wr(`TMC_IDX_CTRL_B, 8'h01);
        cyc_wait(10);
        wr(`TMC_IDX_CTRL_B, 8'h00);
        chk({30'h0, fa, wa}, {30'h0, 1'b0, e});
        rd(`TMC_IDX_COUNT, 8'h12);
        wr(`TMC_IDX_COUNT, 8'h02);
        wr(`TMC_IDX_CTRL_B, 8'h01);
        cyc_wait(10);
        wr(`TMC_IDX_CTRL_B, 8'h00);
        e = ~e;
        chk({30'h0, fa, wa}, {30'h0, 1'b1, e});
        rd(`TMC_IDX_COUNT, 8'h0F);
        wr(`TMC_IDX_FLAGS, 8'h02);
        chk({31'h0, fa}, 32'h0);
        note("match");
        wr(`TMC_IDX_CTRL_A, 8'h42);
        wr(`TMC_IDX_COUNT, 8'h00);
        wr(`TMC_IDX_CTRL_B, 8'h01);
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, `TMC_IDX_COUNT, 8'h00);
            chk({31'h0, rd_data <= 32'h5}, 32'h1);
        end
        wr(`TMC_IDX_CTRL_B, 8'h00);
        wr(`TMC_IDX_FLAGS, 8'h02);
        wr(`TMC_IDX_COUNT, 8'h05);
        wr(`TMC_IDX_CTRL_B, 8'h80);
        rd(`TMC_IDX_COUNT, 8'h05);
        chk({31'h0, fa}, 32'h0);
        wr(`TMC_IDX_CTRL_A, 8'h00);
        note("clear_on_match");
        // Five ticks from FC: three up to FF, then straight down to FD with no hold at top.
        wr(`TMC_IDX_CTRL_A, 8'h01);
        wr(`TMC_IDX_COUNT, 8'hFC);
        wr(`TMC_IDX_CTRL_B, 8'h01);
        cyc_wait(2);
        wr(`TMC_IDX_CTRL_B, 8'h00);
        rd(`TMC_IDX_COUNT, 8'hFD);
        wr(`TMC_IDX_CTRL_A, 8'h00);
        note("phase");
        for (int s = 0; s < 2; s++) begin
            wr(`TMC_IDX_COUNT, 8'h00);
            wr(`TMC_IDX_CTRL_B, 8'(s ? TMC_CS_EXT_FALL : TMC_CS_EXT_RISE));
            repeat (6) begin
                pulse_req <= 1'b1;
                @(posedge clk_i);
                pulse_req <= 1'b0;
                cyc_wait(3);
            end
            cyc_wait(4);
            wr(`TMC_IDX_CTRL_B, 8'h00);
            rd(`TMC_IDX_COUNT, 8'h03);
        end
        note("external");
        end_of_test();
    end
endmodule : timer8_mode_clock_compare_tb

`default_nettype wire

//--- tmc_defines.svh
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define TMC_IDX_CTRL_A 8'h24
`define TMC_IDX_CTRL_B 8'h25
`define TMC_IDX_COUNT 8'h26
`define TMC_IDX_CMP_A 8'h27
`define TMC_IDX_CMP_B 8'h28
`define TMC_IDX_FLAGS 8'h15

// Control register A fields.
`define TMC_A_ACT_HI 7
`define TMC_A_ACT_LO 6
`define TMC_B_ACT_HI 5
`define TMC_B_ACT_LO 4
`define TMC_WM_LOW_HI 1
`define TMC_WM_LOW_LO 0

// Control register B fields.
`define TMC_FORCE_A_BIT 7
`define TMC_FORCE_B_BIT 6
`define TMC_WM_HIGH_BIT 3
`define TMC_CS_HI 2
`define TMC_CS_LO 0

// Flag register fields.
`define TMC_FLAG_A_BIT 1
`define TMC_FLAG_B_BIT 2

// Output action codes.
`define TMC_ACT_OFF 2'h0
`define TMC_ACT_TOGGLE 2'h1
`define TMC_ACT_CLEAR 2'h2
`define TMC_ACT_SET 2'h3

// Fixed top and reset values.
`define TMC_MAX 8'hFF
`define TMC_ZERO8 8'h00

// Prescaler divide masks: tick when the masked low bits are all ones.
`define TMC_DIV8_MASK 10'h007
`define TMC_DIV64_MASK 10'h03F
`define TMC_DIV256_MASK 10'h0FF
`define TMC_DIV1024_MASK 10'h3FF

`endif

//--- tmc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none

module tmc_pin_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pulse_req_i,
    input wire logic wave_a_i,
    input wire logic oe_n_a_i,
    input wire logic wave_b_i,
    input wire logic oe_n_b_i,
    output logic ext_count_pin_o,
    output logic pin_a_o,
    output logic pin_b_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_count_pin_o <= 1'b0;
        end else if (pulse_req_i) begin
            ext_count_pin_o <= ~ext_count_pin_o;
        end
    end

    // released pin level
    // Both pads carry a weak pull-down, so a released pin reads low.
    assign pin_a_o = oe_n_a_i ? 1'b0 : wave_a_i;
    assign pin_b_o = oe_n_b_i ? 1'b0 : wave_b_i;
endmodule : tmc_pin_model

`default_nettype wire

//--- tmc_pkg.sv
package tmc_pkg;

    typedef enum logic [2:0] {
        TMC_WM_NORMAL = 3'h0,
        TMC_WM_PC_FF = 3'h1,
        TMC_WM_CTC = 3'h2,
        TMC_WM_FAST_FF = 3'h3,
        TMC_WM_RES4 = 3'h4,
        TMC_WM_PC_CMP = 3'h5,
        TMC_WM_RES6 = 3'h6,
        TMC_WM_FAST_CMP = 3'h7
    } tmc_wave_mode_t;

    typedef enum logic [2:0] {
        TMC_CS_STOP = 3'h0,
        TMC_CS_DIV1 = 3'h1,
        TMC_CS_DIV8 = 3'h2,
        TMC_CS_DIV64 = 3'h3,
        TMC_CS_DIV256 = 3'h4,
        TMC_CS_DIV1024 = 3'h5,
        TMC_CS_EXT_FALL = 3'h6,
        TMC_CS_EXT_RISE = 3'h7
    } tmc_clk_src_t;

    typedef logic [1:0] tmc_action_t;

endpackage : tmc_pkg

//--- tmc_timer8.sv
// How it works
// RULE1 - Non-PWM channel A action: 0 off, 1 toggle, 2 clear, 3 set on match.
// RULE2 - Channel B action uses the same encoding on its own match.
// RULE3 - Any nonzero action field hands the pin to the waveform output.
// RULE4 - The pin is driven only when its port direction selects output.
// RULE5 - Reserved control bits read zero and ignore writes.
// RULE6 - Modes 0..3: normal, phase PWM top FF, clear-on-match, fast PWM FF.
// RULE7 - Mode 5 phase PWM, 7 fast PWM, both topped by compare A.
// RULE8 - Mode high bit sits in control B bit 3, low bits in control A.
// RULE9 - Force bit applies an immediate match in non-PWM modes only.
// RULE10 - A forced match sets no flag and never clears the counter.
// RULE11 - Force bits are write strobes and always read as zero.
// RULE12 - Software writes zero force bits when writing control B in PWM.
// RULE13 - Clock codes 0..3: stopped, every clock, every 8, every 64.
// RULE14 - Clock codes 4 and 5 count every 256 and 1024 clocks.
// RULE15 - Codes 6 and 7 count falling and rising count pin edges.
// RULE16 - Count pin edges count even when that pin is an output.
// RULE17 - The 8-bit counter is readable and writable at any time.
// RULE18 - A counter write blocks compare matches on the next timer tick.
// RULE19 - Compare A is compared continuously; equality flags or drives A.
// RULE20 - Match flags set on equality and clear when software writes one.
// RULE21 - Phase PWM counts up then down, holding top for one tick; the code turns down from top on the next tick with no hold.
// RULE22 - Match actions and flags take effect on the matching tick.
// RULE23 - All registers reset to zero: counter stopped, outputs off.
`include "tmc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tmc_timer8 (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_count_pin_i,
    input wire logic port_dir_a_i,
    input wire logic port_dir_b_i,
    output logic wave_out_a_o,
    output logic wave_out_a_oe_n_o,
    output logic wave_out_b_o,
    output logic wave_out_b_oe_n_o,
    output logic match_flag_a_o,
    output logic match_flag_b_o
);
    import tmc_pkg::*;

    logic [7:0] ctrl_a_reg;
    logic [3:0] ctrl_b_reg;
    logic [7:0] count_reg;
    logic [7:0] cmp_a_reg;
    logic [7:0] cmp_b_reg;
    logic flag_a_reg;
    logic flag_b_reg;
    logic [9:0] presc_reg;
    logic ext_prev_reg;
    logic block_reg;
    logic count_up_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic wave_a_reg;
    logic wave_b_reg;
    logic oe_a_n_reg;
    logic oe_b_n_reg;
    logic access;
    logic wr;
    logic [7:0] idx;
    tmc_wave_mode_t mode;
    tmc_clk_src_t clk_src;
    tmc_action_t act_a;
    tmc_action_t act_b;
    logic pwm;
    logic [7:0] top;
    logic tick;
    logic cnt_write;
    logic match_a;
    logic match_b;
    logic force_a;
    logic force_b;
    logic flag_write;
    logic [7:0] count_next;
    logic count_up_next;
    function automatic logic action_apply(input tmc_action_t act,
                                          input logic cur);
        case (act)
            `TMC_ACT_TOGGLE: action_apply = ~cur;
            `TMC_ACT_CLEAR: action_apply = 1'b0;
            `TMC_ACT_SET: action_apply = 1'b1;
            default: action_apply = cur;
        endcase
    endfunction : action_apply
    function automatic logic presc_hit(input logic [9:0] cnt,
                                       input logic [9:0] mask);
        presc_hit = ((cnt & mask) == mask);
    endfunction : presc_hit
    assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = access & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    // RULE8 mode assembly
    assign mode = tmc_wave_mode_t'({ctrl_b_reg[`TMC_WM_HIGH_BIT],
                                    ctrl_a_reg[`TMC_WM_LOW_HI:`TMC_WM_LOW_LO]});
    assign clk_src = tmc_clk_src_t'(ctrl_b_reg[`TMC_CS_HI:`TMC_CS_LO]);
    assign act_a = ctrl_a_reg[`TMC_A_ACT_HI:`TMC_A_ACT_LO];
    assign act_b = ctrl_a_reg[`TMC_B_ACT_HI:`TMC_B_ACT_LO];
    assign pwm = (mode == TMC_WM_PC_FF) || (mode == TMC_WM_FAST_FF) ||
                 (mode == TMC_WM_PC_CMP) || (mode == TMC_WM_FAST_CMP);
    assign cnt_write = wr && (idx == `TMC_IDX_COUNT);
    assign flag_write = wr && (idx == `TMC_IDX_FLAGS);
    // RULE9 force strobes
    assign force_a = wr && (idx == `TMC_IDX_CTRL_B) && !pwm &&
                     wb_dat_i[`TMC_FORCE_A_BIT];
    assign force_b = wr && (idx == `TMC_IDX_CTRL_B) && !pwm &&
                     wb_dat_i[`TMC_FORCE_B_BIT];
    // RULE18 blocked matches
    assign match_a = tick && !block_reg && (count_reg == cmp_a_reg);
    assign match_b = tick && !block_reg && (count_reg == cmp_b_reg);
    // RULE6 top selection
    always_comb begin
        case (mode)
            // RULE7 compare A as top
            TMC_WM_CTC, TMC_WM_PC_CMP, TMC_WM_FAST_CMP: top = cmp_a_reg;
            default: top = `TMC_MAX;
        endcase
    end
    // RULE13 clock select
    always_comb begin
        case (clk_src)
            TMC_CS_DIV1: tick = 1'b1;
            TMC_CS_DIV8: tick = presc_hit(presc_reg, `TMC_DIV8_MASK);
            TMC_CS_DIV64: tick = presc_hit(presc_reg, `TMC_DIV64_MASK);
            // RULE14 long prescales
            TMC_CS_DIV256: tick = presc_hit(presc_reg, `TMC_DIV256_MASK);
            TMC_CS_DIV1024: tick = presc_hit(presc_reg, `TMC_DIV1024_MASK);
            // RULE15 count pin edges
            TMC_CS_EXT_FALL: tick = ext_prev_reg & ~ext_count_pin_i;
            TMC_CS_EXT_RISE: tick = ~ext_prev_reg & ext_count_pin_i;
            default: tick = 1'b0;
        endcase
    end
    // Count sequence for the current mode; reserved modes count as normal.
    always_comb begin
        count_next = count_reg;
        count_up_next = count_up_reg;
        case (mode)
            TMC_WM_PC_FF, TMC_WM_PC_CMP: begin
                // RULE21 dual slope
                if (count_up_reg && count_reg >= top) begin
                    count_up_next = 1'b0;
                    count_next = count_reg - 8'h01;
                end else if (!count_up_reg && count_reg == `TMC_ZERO8) begin
                    count_up_next = 1'b1;
                    count_next = 8'h01;
                end else if (count_up_reg) begin
                    count_next = count_reg + 8'h01;
                end else begin
                    count_next = count_reg - 8'h01;
                end
            end
            TMC_WM_CTC, TMC_WM_FAST_CMP, TMC_WM_FAST_FF: begin
                count_next = (count_reg == top) ? `TMC_ZERO8 :
                             count_reg + 8'h01;
            end
            default: count_next = count_reg + 8'h01;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_reg <= 10'h000;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end
    // RULE16 pin sampled whatever its direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_count_pin_i;
        end
    end
    // RULE23 zero reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_reg <= `TMC_ZERO8;
            ctrl_b_reg <= 4'h0;
            cmp_a_reg <= `TMC_ZERO8;
            cmp_b_reg <= `TMC_ZERO8;
        end else if (wr) begin
            // RULE5 reserved bits not stored
            if (idx == `TMC_IDX_CTRL_A) begin
                ctrl_a_reg <= wb_dat_i[7:0] & 8'hF3;
            end
            if (idx == `TMC_IDX_CTRL_B) begin
                ctrl_b_reg <= wb_dat_i[3:0];
            end
            // RULE19 compare value
            if (idx == `TMC_IDX_CMP_A) begin
                cmp_a_reg <= wb_dat_i[7:0];
            end
            if (idx == `TMC_IDX_CMP_B) begin
                cmp_b_reg <= wb_dat_i[7:0];
            end
        end
    end
    // RULE17 software write beats the tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= `TMC_ZERO8;
            count_up_reg <= 1'b1;
        end else if (cnt_write) begin
            count_reg <= wb_dat_i[7:0];
        end else if (tick) begin
            count_reg <= count_next;
            count_up_reg <= count_up_next;
        end
    end
    // RULE18 one-tick block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_reg <= 1'b0;
        end else if (cnt_write) begin
            block_reg <= 1'b1;
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end
    // RULE10 forced matches set no flag
    // RULE20 set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_a_reg <= 1'b0;
            flag_b_reg <= 1'b0;
        end else begin
            if (match_a) begin
                flag_a_reg <= 1'b1;
            end else if (flag_write && wb_dat_i[`TMC_FLAG_A_BIT]) begin
                flag_a_reg <= 1'b0;
            end
            if (match_b) begin
                flag_b_reg <= 1'b1;
            end else if (flag_write && wb_dat_i[`TMC_FLAG_B_BIT]) begin
                flag_b_reg <= 1'b0;
            end
        end
    end

    // PWM waveform shaping is not built here; outputs hold in PWM modes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
        end else if (!pwm) begin
            // RULE1 channel A action
            // RULE22 on the matching tick
            if (match_a || force_a) begin
                wave_a_reg <= action_apply(act_a, wave_a_reg);
            end
            // RULE2 channel B action
            if (match_b || force_b) begin
                wave_b_reg <= action_apply(act_b, wave_b_reg);
            end
        end
    end

    // RULE3 pin takeover
    // RULE4 direction gate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_a_n_reg <= 1'b1;
            oe_b_n_reg <= 1'b1;
        end else begin
            oe_a_n_reg <= !((act_a != `TMC_ACT_OFF) && port_dir_a_i);
            oe_b_n_reg <= !((act_b != `TMC_ACT_OFF) && port_dir_b_i);
        end
    end

    // Read data is registered so that the bus answers one cycle later.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= access;
            rdata_reg <= 32'h0000_0000;
            if (access && !wb_we_i) begin
                case (idx)
                    `TMC_IDX_CTRL_A: rdata_reg[7:0] <= ctrl_a_reg;
                    // RULE11 force bits read zero
                    `TMC_IDX_CTRL_B: rdata_reg[3:0] <= ctrl_b_reg;
                    `TMC_IDX_COUNT: rdata_reg[7:0] <= count_reg;
                    `TMC_IDX_CMP_A: rdata_reg[7:0] <= cmp_a_reg;
                    `TMC_IDX_CMP_B: rdata_reg[7:0] <= cmp_b_reg;
                    `TMC_IDX_FLAGS: begin
                        rdata_reg[`TMC_FLAG_A_BIT] <= flag_a_reg;
                        rdata_reg[`TMC_FLAG_B_BIT] <= flag_b_reg;
                    end
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign wave_out_a_o = wave_a_reg;
    assign wave_out_b_o = wave_b_reg;
    assign wave_out_a_oe_n_o = oe_a_n_reg;
    assign wave_out_b_oe_n_o = oe_b_n_reg;
    assign match_flag_a_o = flag_a_reg;
    assign match_flag_b_o = flag_b_reg;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_bus_answer;
        s_req |=> s_ack_once;
    endproperty
    a_bus_answer: assert property (p_bus_answer) // RULE17
        else $error("Bus request not answered in one cycle.");
    property p_toggle_a;
        (match_a && !pwm && act_a == `TMC_ACT_TOGGLE)
            |=> wave_out_a_o != $past(wave_out_a_o);
    endproperty
    a_toggle_a: assert property (p_toggle_a) // RULE1
        else $error("Channel A did not toggle on match.");
    property p_clear_b;
        ((match_b || force_b) && !pwm && act_b == `TMC_ACT_CLEAR)
            |=> !wave_out_b_o;
    endproperty
    a_clear_b: assert property (p_clear_b) // RULE2
        else $error("Channel B did not clear on match.");
    property p_pin_drive;
        (act_a != `TMC_ACT_OFF && port_dir_a_i) |=> !wave_out_a_oe_n_o;
    endproperty
    a_pin_drive: assert property (p_pin_drive) // RULE3
        else $error("Channel A pin not driven.");
    property p_pin_release;
        (!port_dir_b_i || act_b == `TMC_ACT_OFF) |=> wave_out_b_oe_n_o;
    endproperty
    a_pin_release: assert property (p_pin_release) // RULE4
        else $error("Channel B pin driven without direction.");
    property p_ctrl_b_read;
        (s_req and (!wb_we_i && idx == `TMC_IDX_CTRL_B))
            |=> wb_dat_o[7:4] == 4'h0;
    endproperty
    a_ctrl_b_read: assert property (p_ctrl_b_read) // RULE11
        else $error("Force or reserved bits read nonzero.");
    property p_force_no_flag;
        (force_a && !match_a && !flag_a_reg) |=> !match_flag_a_o;
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) // RULE10
        else $error("Forced match set a flag.");
    property p_block;
        (block_reg && tick && !force_a) |=> $stable(wave_out_a_o);
    endproperty
    a_block: assert property (p_block) // RULE18
        else $error("Match not blocked after counter write.");
    property p_div1;
        (clk_src == TMC_CS_DIV1 && mode == TMC_WM_NORMAL && !cnt_write)
            |=> count_reg == $past(count_reg) + 8'h01;
    endproperty
    a_div1: assert property (p_div1) // RULE13
        else $error("Counter did not advance every clock.");
    property p_stopped;
        (clk_src == TMC_CS_STOP && !cnt_write) |=> $stable(count_reg);
    endproperty
    a_stopped: assert property (p_stopped) // RULE13
        else $error("Stopped counter changed.");
    property p_flag_set;
        match_a |=> match_flag_a_o;
    endproperty
    a_flag_set: assert property (p_flag_set) // RULE20
        else $error("Match flag A not set.");
    property p_pc_top;
        (tick && !cnt_write && mode == TMC_WM_PC_FF && count_up_reg &&
         count_reg == 8'hFF) |=> count_reg == 8'hFE && !count_up_reg;
    endproperty
    a_pc_top: assert property (p_pc_top) // RULE21
        else $error("Phase PWM did not turn at top.");
endmodule : tmc_timer8

`default_nettype wire
